// >>> verilog/tacc_defines.vh
// constants for the thermal alarm configuration block
// included by tacc_core.v; holds definitions only
`ifndef TACC_DEFINES_VH
`define TACC_DEFINES_VH

// register pointer of the configuration word
`define TACC_CFG_ADDR 8'h01
`define TACC_CFG_RESET 16'h0000

// configuration field positions
`define TACC_HYST_HI 10
`define TACC_HYST_LO 9
`define TACC_SHUT_BIT 8
`define TACC_CLOCK_BIT 7
`define TACC_WLOCK_BIT 6
`define TACC_CLEAR_BIT 5
`define TACC_STAT_BIT 4
`define TACC_OE_BIT 3
`define TACC_CRIT_ONLY_BIT 2
`define TACC_POL_BIT 1
`define TACC_MODE_BIT 0

// hysteresis codes and amounts in temperature lsbs of 0.0625 degC
`define TACC_HYST_OFF 2'h0
`define TACC_HYST_1P5 2'h1
`define TACC_HYST_3 2'h2
`define TACC_HYST_6 2'h3
`define TACC_HYS_1P5_LSB 14'h0018
`define TACC_HYS_3_LSB 14'h0030
`define TACC_HYS_6_LSB 14'h0060

`endif

// >>> verilog/tacc_core.v
// configuration register and alert control of a module temperature sensor
// assumes a serial-bus front end that turns transfers into one-cycle
// register strobes, and a converter that delivers 13-bit signed samples.
`timescale 1ns/1ps
`include "tacc_defines.vh"

module tacc_core (
  // clock and power-on reset
  input wire core_clk,
  input wire nrst,
  // register strobes from the serial front end
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // conversion results and trip values, 13-bit two's complement
  input wire temp_valid,
  input wire [12:0] temp_value,
  input wire [12:0] upper_trip,
  input wire [12:0] lower_trip,
  input wire [12:0] crit_trip,
  // trip status for the temperature read-back word
  output reg above_window,
  output reg below_window,
  output reg above_crit,
  // controls seen by the converter and trip registers
  output reg sensor_shutdown,
  output reg crit_trip_locked,
  output reg window_trip_locked,
  // open-drain alert pin
  output reg alert_out,
  output reg alert_oe
);

  reg [1:0] hyst_sel_reg;
  reg shutdown_reg;
  reg crit_lock_reg;
  reg win_lock_reg;
  reg out_en_reg;
  reg crit_only_reg;
  reg pol_reg;
  reg mode_reg;
  reg above_reg;
  reg below_reg;
  reg crit_reg;
  reg cond_d_reg;
  reg latch_reg;

  // next values of the configuration fields and the interrupt latch
  reg [1:0] hyst_sel_next;
  reg shutdown_next;
  reg crit_lock_next;
  reg win_lock_next;
  reg out_en_next;
  reg crit_only_next;
  reg pol_next;
  reg mode_next;
  reg latch_next;
  reg cond_rise;
  reg [15:0] cfg_word;

  reg [13:0] hys_amt;
  reg above_next;
  reg below_next;
  reg crit_next;
  reg cond;
  reg asserted;
  reg pin_low;
  wire locked;
  wire cfg_wr;
  wire [13:0] t_s;
  wire [13:0] up_s;
  wire [13:0] lo_s;
  wire [13:0] cr_s;
  wire [13:0] up_h;
  wire [13:0] lo_h;
  wire [13:0] cr_h;
  wire [38:0] trips_all;
  wire [41:0] trips_s;
  wire [41:0] trips_h;
  wire sample_ok;
  wire cfg_rd;
  wire clear_req;
  // comparison results for the sample being taken
  wire over_upper;
  wire clear_upper;
  wire reach_lower;
  wire set_lower;
  wire reach_crit;
  wire clear_crit;

  assign locked = crit_lock_reg | win_lock_reg;
  // a locked field is simply skipped, so the bus transfer still completes
  assign cfg_wr = reg_wr & (reg_addr == `TACC_CFG_ADDR);

  // strobe decode and the sample qualifier
  assign cfg_rd = reg_rd & (reg_addr == `TACC_CFG_ADDR);
  assign clear_req = cfg_wr & reg_wdata[`TACC_CLEAR_BIT];
  assign sample_ok = temp_valid & ~shutdown_reg;

  // sign-extend by one bit so subtracting six degrees cannot wrap
  assign t_s = {temp_value[12], temp_value};
  assign trips_all = {crit_trip, lower_trip, upper_trip};

  // each trip gets the same sign extension and hysteresis subtractor;
  // slot 0 is the upper, slot 1 the lower and slot 2 the critical trip
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_trip
      wire [12:0] trip_raw;
      assign trip_raw = trips_all[13*k +: 13];
      assign trips_s[14*k +: 14] = {trip_raw[12], trip_raw};
      assign trips_h[14*k +: 14] = trips_s[14*k +: 14] - hys_amt;
    end
  endgenerate

  assign up_s = trips_s[13:0];
  assign lo_s = trips_s[27:14];
  assign cr_s = trips_s[41:28];
  assign up_h = trips_h[13:0];
  assign lo_h = trips_h[27:14];
  assign cr_h = trips_h[41:28];

  // comparisons are signed, so trips below zero behave as temperatures do
  assign over_upper = $signed(t_s) > $signed(up_s);
  assign clear_upper = $signed(t_s) <= $signed(up_h);
  assign reach_lower = $signed(t_s) >= $signed(lo_s);
  assign set_lower = $signed(t_s) <= $signed(lo_h);
  assign reach_crit = $signed(t_s) >= $signed(cr_s);
  assign clear_crit = $signed(t_s) < $signed(cr_h);

  always @* begin
    case (hyst_sel_reg)
      `TACC_HYST_1P5: hys_amt = `TACC_HYS_1P5_LSB;
      `TACC_HYST_3: hys_amt = `TACC_HYS_3_LSB;
      `TACC_HYST_6: hys_amt = `TACC_HYS_6_LSB;
      default: hys_amt = 14'h0000;
    endcase
  end

  // window and critical tracking with hysteresis; between the two thresholds
  // a flag keeps its old value, which is what makes the band sticky
  always @* begin
    above_next = above_reg;
    below_next = below_reg;
    crit_next = crit_reg;
    if (sample_ok) begin
      if (over_upper) begin
        above_next = 1'b1;
      end else if (clear_upper) begin
        above_next = 1'b0;
      end
      // at equality with no hysteresis the clear condition takes priority
      if (reach_lower) begin
        below_next = 1'b0;
      end else if (set_lower) begin
        below_next = 1'b1;
      end
      if (reach_crit) begin
        crit_next = 1'b1;
      end else if (clear_crit) begin
        crit_next = 1'b0;
      end
    end
  end

  // alert condition and pin drive
  always @* begin
    if (crit_only_reg) begin
      cond = crit_next;
    end else begin
      cond = above_next | below_next | crit_next;
    end
    if (mode_reg) begin
      asserted = latch_reg;
    end else begin
      asserted = cond;
    end
    // open drain: the pin is pulled low for the active-low asserted state
    // or for the active-high idle state; disabled output stays released
    pin_low = out_en_reg & (asserted ^ pol_reg);
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hyst_sel_reg <= `TACC_HYST_OFF;
      shutdown_reg <= 1'b0;
      crit_lock_reg <= 1'b0;
      win_lock_reg <= 1'b0;
      out_en_reg <= 1'b0;
      crit_only_reg <= 1'b0;
      pol_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else begin
      // the flops only load next values; every decision sits in the block below
      hyst_sel_reg <= hyst_sel_next;
      shutdown_reg <= shutdown_next;
      crit_lock_reg <= crit_lock_next;
      win_lock_reg <= win_lock_next;
      out_en_reg <= out_en_next;
      crit_only_reg <= crit_only_next;
      pol_reg <= pol_next;
      mode_reg <= mode_next;
    end
  end

  // configuration next state; locked fields keep their value so a mixed
  // write still completes on the bus and only the open fields move
  always @* begin
    hyst_sel_next = hyst_sel_reg;
    shutdown_next = shutdown_reg;
    crit_lock_next = crit_lock_reg;
    win_lock_next = win_lock_reg;
    out_en_next = out_en_reg;
    crit_only_next = crit_only_reg;
    pol_next = pol_reg;
    mode_next = mode_reg;

    if (cfg_wr) begin
      if (!locked) begin
        hyst_sel_next = reg_wdata[`TACC_HYST_HI:`TACC_HYST_LO];
        out_en_next = reg_wdata[`TACC_OE_BIT];
        crit_only_next = reg_wdata[`TACC_CRIT_ONLY_BIT];
        pol_next = reg_wdata[`TACC_POL_BIT];
        mode_next = reg_wdata[`TACC_MODE_BIT];
      end
      // clearing shutdown is always allowed, setting it only while open
      if (!reg_wdata[`TACC_SHUT_BIT] || !locked) begin
        shutdown_next = reg_wdata[`TACC_SHUT_BIT];
      end
      // lock bits are sticky: a written zero never clears them
      if (reg_wdata[`TACC_CLOCK_BIT]) begin
        crit_lock_next = 1'b1;
      end
      if (reg_wdata[`TACC_WLOCK_BIT]) begin
        win_lock_next = 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      above_reg <= 1'b0;
      below_reg <= 1'b0;
      crit_reg <= 1'b0;
      cond_d_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      above_reg <= above_next;
      below_reg <= below_next;
      crit_reg <= crit_next;
      cond_d_reg <= cond;
      latch_reg <= latch_next;
    end
  end

  // interrupt latch: a new event in the clearing cycle wins over the clear,
  // and leaving interrupt mode drops whatever was pending
  always @* begin
    cond_rise = cond & ~cond_d_reg;
    latch_next = latch_reg;
    if (mode_reg && cond_rise && !shutdown_reg) begin
      latch_next = 1'b1;
    end else if (clear_req && mode_reg) begin
      latch_next = 1'b0;
    end else if (!mode_reg) begin
      latch_next = 1'b0;
    end
  end

  // read-back image; the clear bit is write-only and always reads zero, and
  // the status bit is not stored, so writing it has no effect
  always @* begin
    cfg_word = `TACC_CFG_RESET;
    cfg_word[`TACC_HYST_HI:`TACC_HYST_LO] = hyst_sel_reg;
    cfg_word[`TACC_SHUT_BIT] = shutdown_reg;
    cfg_word[`TACC_CLOCK_BIT] = crit_lock_reg;
    cfg_word[`TACC_WLOCK_BIT] = win_lock_reg;
    cfg_word[`TACC_CLEAR_BIT] = 1'b0;
    cfg_word[`TACC_STAT_BIT] = out_en_reg & asserted;
    cfg_word[`TACC_OE_BIT] = out_en_reg;
    cfg_word[`TACC_CRIT_ONLY_BIT] = crit_only_reg;
    cfg_word[`TACC_POL_BIT] = pol_reg;
    cfg_word[`TACC_MODE_BIT] = mode_reg;
  end

  // registered outputs; status and control copies take the next values so
  // that each port changes at the same edge as the state behind it
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      above_window <= 1'b0;
      below_window <= 1'b0;
      above_crit <= 1'b0;
      sensor_shutdown <= 1'b0;
      crit_trip_locked <= 1'b0;
      window_trip_locked <= 1'b0;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      if (cfg_rd) begin
        reg_rdata <= cfg_word;
      end else if (reg_rd) begin
        reg_rdata <= 16'h0000;
      end
      above_window <= above_next;
      below_window <= below_next;
      above_crit <= crit_next;
      sensor_shutdown <= shutdown_next;
      crit_trip_locked <= crit_lock_next;
      window_trip_locked <= win_lock_next;
      // open-drain data is always low; only the enable moves the pin
      alert_out <= 1'b0;
      alert_oe <= pin_low;
    end
  end

endmodule // tacc_core

// >>> tb/tacc_core_monitor.sv
// port assertions for tacc_core
// assumes one clock core_clk and asynchronous active-low nrst
`timescale 1ns/1ps
module tacc_mon (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // register strobes and samples
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire temp_valid,
  input wire [12:0] temp_value,
  input wire [12:0] upper_trip,
  input wire [12:0] lower_trip,
  input wire [12:0] crit_trip,
  // status and locks
  input wire above_window,
  input wire below_window,
  input wire above_crit,
  input wire sensor_shutdown,
  input wire crit_trip_locked,
  input wire window_trip_locked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire wr1 = reg_wr && reg_addr == 8'h01;
  wire smp = temp_valid && !sensor_shutdown;
  wire lk = crit_trip_locked || window_trip_locked;
  property p_above; smp && $signed(temp_value) > $signed(upper_trip) |=> above_window; endproperty
  a_above: assert property (p_above) else $error("above flag late");
  property p_below; smp && $signed(temp_value) >= $signed(lower_trip) |=> !below_window; endproperty
  a_below: assert property (p_below) else $error("below flag stuck");
  property p_crit; smp && $signed(temp_value) >= $signed(crit_trip) |=> above_crit; endproperty
  a_crit: assert property (p_crit) else $error("crit flag late");
  property p_cset; wr1 && reg_wdata[7] |=> crit_trip_locked [*3]; endproperty
  a_cset: assert property (p_cset) else $error("crit lock lost");
  property p_wkeep; window_trip_locked |=> window_trip_locked; endproperty
  a_wkeep: assert property (p_wkeep) else $error("window lock cleared");
  property p_shref; wr1 && lk && !sensor_shutdown |=> !sensor_shutdown; endproperty
  a_shref: assert property (p_shref) else $error("shutdown set while locked");
  property p_shclr; wr1 && !reg_wdata[8] |=> !sensor_shutdown; endproperty
  a_shclr: assert property (p_shclr) else $error("shutdown not cleared");
  property p_shold; sensor_shutdown |=> $stable({above_window, below_window, above_crit}); endproperty
  a_shold: assert property (p_shold) else $error("status moved in shutdown");
  c_above: cover property (above_window ##1 !above_window);
  c_lock: cover property (wr1 && window_trip_locked);
  c_shut: cover property (sensor_shutdown && temp_valid);
endmodule // tacc_mon

// >>> tb/tacc_host.sv
// register-strobe host standing in for the serial front end
// assumes it is called just after a falling edge of core_clk
`timescale 1ns/1ps
module tacc_host (
  // clock
  input wire core_clk,
  // strobes and read data
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [15:0] reg_wdata,
  input wire [15:0] reg_rdata
);
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = 26'h0;
  end
  // released address and data lines carry inverted values and both strobes drop low, so stale data never looks valid
  task xfer(input w, input [7:0] a, input [15:0] d, output [15:0] q);
    begin
      {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, w, !w, d};
      @(negedge core_clk);
      q = reg_rdata;
      {reg_addr, reg_wr, reg_rd, reg_wdata} = {~a, 2'b00, ~d};
      @(negedge core_clk);
    end
  endtask
endmodule // tacc_host

// >>> tb/tacc_core_tb_top.sv
// self-checking bench for tacc_core with a behavioural strobe host
// assumes the host and core share core_clk; inputs change at falling edges
`timescale 1ns/1ps
module tacc_core_tb_top;
  reg core_clk = 0, nrst = 0, temp_valid = 0, ab = 0, bl = 0, cr = 0;
  reg [12:0] temp_value = 0;
  integer up = 400, lo = 80, ct = 800, h = 0, mismatches = 0, n_tests = 0, i, tv;
  wire [12:0] upper_trip = up, lower_trip = lo, crit_trip = ct;
  wire [7:0] reg_addr;
  wire reg_wr, reg_rd, above_window, below_window, above_crit, sensor_shutdown;
  wire crit_trip_locked, window_trip_locked, alert_out, alert_oe;
  wire [15:0] reg_wdata, reg_rdata;
  reg [15:0] q, cfg = 0;
  always #5 core_clk = ~core_clk;
  tacc_host host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  tacc_core dut_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_valid(temp_valid),
    .temp_value(temp_value), .upper_trip(upper_trip), .lower_trip(lower_trip),
    .crit_trip(crit_trip), .above_window(above_window), .below_window(below_window),
    .above_crit(above_crit), .sensor_shutdown(sensor_shutdown), .alert_out(alert_out),
    .crit_trip_locked(crit_trip_locked), .window_trip_locked(window_trip_locked),
    .alert_oe(alert_oe));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rcfg(input [7:0] a, input [15:0] e);
    begin
      host_u.xfer(0, a, 16'h0000, q);
      chk(q, e);
    end
  endtask
  task smp(input integer t);
    reg c;
    begin
      temp_value = t[12:0];
      temp_valid = 1;
      @(negedge core_clk);
      temp_valid = 0;
      if (!cfg[8]) begin
        ab = t > up ? 1 : (t <= up - h ? 0 : ab);
        bl = t >= lo ? 0 : (t <= lo - h ? 1 : bl);
        cr = t >= ct ? 1 : (t < ct - h ? 0 : cr);
      end
      c = cfg[2] ? cr : ab | bl | cr;
      chk({above_crit, above_window, below_window}, {cr, ab, bl});
      if (!cfg[0]) begin
        chk(alert_oe, cfg[3] & (c ^ cfg[1]));
        rcfg(8'h01, cfg | {11'h0, cfg[3] & c, 4'h0});
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    i = $urandom(69830);
    repeat (3) @(negedge core_clk);
    nrst = 1;
    rcfg(8'h01, 16'h0000);
    for (i = 0; i < 160; i = i + 1) begin
      if (i % 20 == 0) begin
        cfg = ($urandom & 16'h000E) | ((i / 40) << 9);
        h = (i / 40) ? 12 << (i / 40) : 0;
        host_u.xfer(1, 8'h01, cfg, q);
      end
      // even steps sit on a boundary or its hysteresis edge, plus or minus one
      tv = (i[2] ? up : (i[3] ? lo : ct)) - (i[1] ? 0 : h) + $urandom_range(2) - 1;
      smp(i[0] ? $urandom_range(1000) - 150 : tv);
    end
    cfg = 0;
    h = 0;
    host_u.xfer(1, 8'h01, 16'h0000, q);
    smp(200);
    cfg = 16'h0009;
    host_u.xfer(1, 8'h01, cfg, q);
    smp(up + 10);
    smp(200);
    chk(alert_oe, 1);
    chk(alert_out, 0);
    rcfg(8'h01, 16'h0019);
    host_u.xfer(1, 8'h01, 16'h0029, q);
    rcfg(8'h01, 16'h0009);
    chk(alert_oe, 0);
    cfg = 16'h0140;
    host_u.xfer(1, 8'h01, cfg, q);
    smp(up + 10);
    chk({window_trip_locked, sensor_shutdown}, 2'b11);
    host_u.xfer(1, 8'h01, 16'h060F, q);
    rcfg(8'h01, 16'h0040);
    host_u.xfer(1, 8'h01, 16'h0100, q);
    host_u.xfer(1, 8'h02, 16'hFFFF, q);
    rcfg(8'h01, 16'h0040);
    rcfg(8'h02, 16'h0000);
    nrst = 0;
    @(negedge core_clk);
    nrst = 1;
    rcfg(8'h01, 16'h0000);
    host_u.xfer(1, 8'h01, 16'h0080, q);
    host_u.xfer(1, 8'h01, 16'h0000, q);
    rcfg(8'h01, 16'h0080);
    chk(crit_trip_locked, 1);
    final_report;
  end
endmodule // tacc_core_tb_top
bind tacc_core tacc_mon mon_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .temp_valid(temp_valid), .temp_value(temp_value),
  .upper_trip(upper_trip), .lower_trip(lower_trip), .crit_trip(crit_trip),
  .above_window(above_window), .below_window(below_window), .above_crit(above_crit),
  .sensor_shutdown(sensor_shutdown), .crit_trip_locked(crit_trip_locked),
  .window_trip_locked(window_trip_locked));
